// ### design/idw_dac_receiver.sv
// Receive-only two-wire slave of a 12-bit converter: address match,
// acknowledge, control and data bytes, power modes and wake timing.
// Assumes an external open-drain wire built from sdaOe and a bus master
// on the far side; the bus clock pin also clocks the link sampler.

`timescale 1ns/1ps
`default_nettype none

module idw_dac_receiver (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        scl,
    input  wire logic        sdaIn,
    input  wire logic        addressSelectPin,
    input  wire logic        lowSupply,
    output logic             sdaOut,
    output logic             sdaOe,
    output logic [11:0]      codeOut,
    output logic             powerModeHighBit,
    output logic             powerModeLowBit,
    output logic             poweredDown,
    output logic             ampConnected,
    output logic             termLow,
    output logic             termHigh,
    output logic             termOpen,
    output logic             outputReady,
    output logic             updatePulse,
    output logic             addressed
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]          sclSync;
        logic [2:0]          sdaSync;
        logic [2:0]          selSync;
        logic [2:0]          togSync;
        logic                sclLvl;
        logic                sdaLvl;
        logic [1:0]          strapCnt;
        logic                strapDone;
        logic                selBit;
        idw_pkg::idw_phase_t phase;
        logic [3:0]          bitCnt;
        logic [7:0]          shift;
        logic                ackDrive;
        logic [5:0]          ctrlHold;
        logic [11:0]         code;
        logic [1:0]          mode;
        logic [7:0]          wakeCnt;
        logic                update;
        logic                pdOut;
        logic                ampOut;
        logic                termLo;
        logic                termHi;
        logic                termOp;
        logic                ready;
    } idw_state_t;

    idw_state_t cur_ff;
    idw_state_t nxt_state;

    logic       bitToggle;
    logic       bitValue;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;
    logic       bitEvent;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Own address with the latched select bit, or the broadcast byte.
    // General call and ten-bit headers never match either form.
    function automatic logic isOurAddress(input logic [7:0] addrByte,
                                          input logic       sel);
        logic [7:0] own;
        own = {idw_pkg::ADDR_FIXED, sel, idw_pkg::DIR_WRITE};
        isOurAddress = (addrByte == own) ||
                       (addrByte == idw_pkg::ADDR_BROADCAST);
    endfunction

    function automatic logic isPowerDown(input logic [1:0] mode);
        isPowerDown = (mode != idw_pkg::MODE_NORMAL);
    endfunction

    // ------------------------------------------------------------------
    // Link-clock sampler
    // ------------------------------------------------------------------
    idw_link_sampler u_sampler (
        .sclLink   (scl),
        .rst_n     (rst_n),
        .sdaIn     (sdaIn),
        .bitToggle (bitToggle),
        .bitValue  (bitValue)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state        = cur_ff;
        nxt_state.update = 1'b0;

        // Three-stage pin synchronisers; a level is accepted only once
        // the second and third stages agree.
        nxt_state.sclSync = {cur_ff.sclSync[1:0], scl};
        nxt_state.sdaSync = {cur_ff.sdaSync[1:0], sdaIn};
        nxt_state.selSync = {cur_ff.selSync[1:0], addressSelectPin};
        nxt_state.togSync = {cur_ff.togSync[1:0], bitToggle};
        if (cur_ff.sclSync[1] == cur_ff.sclSync[2]) begin
            nxt_state.sclLvl = cur_ff.sclSync[2];
        end
        if (cur_ff.sdaSync[1] == cur_ff.sdaSync[2]) begin
            nxt_state.sdaLvl = cur_ff.sdaSync[2];
        end

        sclFall   = cur_ff.sclLvl & ~nxt_state.sclLvl;
        startCond = cur_ff.sclLvl & nxt_state.sclLvl &
                    cur_ff.sdaLvl & ~nxt_state.sdaLvl;
        stopCond  = cur_ff.sclLvl & nxt_state.sclLvl &
                    ~cur_ff.sdaLvl & nxt_state.sdaLvl;
        bitEvent  = cur_ff.togSync[1] ^ cur_ff.togSync[2];

        // The select level is caught once, after the synchroniser has
        // filled following reset release, and never again.
        if (!cur_ff.strapDone) begin
            if (cur_ff.strapCnt == idw_pkg::STRAP_SETTLE) begin
                // Wait until the last two stages agree on the level.
                if (cur_ff.selSync[1] == cur_ff.selSync[2]) begin
                    nxt_state.selBit    = cur_ff.selSync[2];
                    nxt_state.strapDone = 1'b1;
                end
            end else begin
                nxt_state.strapCnt = cur_ff.strapCnt + 2'h1;
            end
        end

        if (cur_ff.wakeCnt != 8'h00) begin
            nxt_state.wakeCnt = cur_ff.wakeCnt - 8'h01;
        end

        if (startCond) begin
            // A repeated start mid-session re-enters the address phase.
            nxt_state.phase    = idw_pkg::PH_ADDR;
            nxt_state.bitCnt   = 4'h0;
            nxt_state.ackDrive = 1'b0;
        end else if (stopCond) begin
            nxt_state.phase    = idw_pkg::PH_IDLE;
            nxt_state.bitCnt   = 4'h0;
            nxt_state.ackDrive = 1'b0;
        end else if (cur_ff.phase != idw_pkg::PH_IDLE) begin
            // Count rising edges; the ninth is the acknowledge slot.
            if (bitEvent && (cur_ff.bitCnt != idw_pkg::ACK_SLOT)) begin
                if (cur_ff.bitCnt < idw_pkg::BITS_PER_BYTE) begin
                    nxt_state.shift = {cur_ff.shift[6:0], bitValue};
                end
                nxt_state.bitCnt = cur_ff.bitCnt + 4'h1;
            end

            if (sclFall && (nxt_state.bitCnt == idw_pkg::BITS_PER_BYTE)) begin
                // Byte complete: decide on the acknowledge while the
                // clock is low, ahead of the ninth pulse.
                case (cur_ff.phase)
                    idw_pkg::PH_ADDR: begin
                        if (isOurAddress(cur_ff.shift,
                                         cur_ff.selBit)) begin
                            nxt_state.ackDrive = 1'b1;
                        end else begin
                            nxt_state.phase  = idw_pkg::PH_IDLE;
                            nxt_state.bitCnt = 4'h0;
                        end
                    end
                    idw_pkg::PH_CTRL: begin
                        nxt_state.ctrlHold = cur_ff.shift[5:0];
                        nxt_state.ackDrive = 1'b1;
                    end
                    idw_pkg::PH_DATA: begin
                        nxt_state.ackDrive = 1'b1;
                    end
                    default: begin
                        nxt_state.ackDrive = 1'b0;
                    end
                endcase
            end else if (sclFall &&
                         (nxt_state.bitCnt == idw_pkg::ACK_SLOT)) begin
                // End of the acknowledge pulse: release the line and
                // move on to the next byte of the pair.
                nxt_state.ackDrive = 1'b0;
                nxt_state.bitCnt   = 4'h0;
                case (cur_ff.phase)
                    idw_pkg::PH_ADDR: begin
                        nxt_state.phase = idw_pkg::PH_CTRL;
                    end
                    idw_pkg::PH_CTRL: begin
                        nxt_state.phase = idw_pkg::PH_DATA;
                    end
                    idw_pkg::PH_DATA: begin
                        nxt_state.code = {cur_ff.ctrlHold[idw_pkg::HIGH_MSB:
                                                          idw_pkg::HIGH_LSB],
                                          cur_ff.shift};
                        nxt_state.mode = cur_ff.ctrlHold[idw_pkg::MODE_MSB:
                                                         idw_pkg::MODE_LSB];
                        nxt_state.update = 1'b1;
                        nxt_state.phase  = idw_pkg::PH_CTRL;
                        if (isPowerDown(cur_ff.mode) &&
                            !isPowerDown(nxt_state.mode)) begin
                            nxt_state.wakeCnt = lowSupply ?
                                                idw_pkg::WAKE_3V_CYC :
                                                idw_pkg::WAKE_5V_CYC;
                        end else if (isPowerDown(nxt_state.mode)) begin
                            nxt_state.wakeCnt = 8'h00;
                        end
                    end
                    default: begin
                        nxt_state.phase = idw_pkg::PH_IDLE;
                    end
                endcase
            end
        end

        // Output decodes are registered so that the pins never glitch.
        nxt_state.pdOut   = isPowerDown(nxt_state.mode);
        nxt_state.ampOut  = !isPowerDown(nxt_state.mode);
        nxt_state.termLo  = (nxt_state.mode == idw_pkg::MODE_PD_1K);
        nxt_state.termHi  = (nxt_state.mode == idw_pkg::MODE_PD_100K);
        nxt_state.termOp  = (nxt_state.mode == idw_pkg::MODE_PD_OPEN);
        nxt_state.ready   = !isPowerDown(nxt_state.mode) &&
                            (nxt_state.wakeCnt == 8'h00);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cur_ff           <= '0;
            cur_ff.sclLvl    <= 1'b1;
            cur_ff.sdaLvl    <= 1'b1;
            // Line synchronisers start at the idle high level of the bus,
            // so no false edge follows reset.
            cur_ff.sclSync   <= 3'h7;
            cur_ff.sdaSync   <= 3'h7;
            cur_ff.ampOut    <= 1'b1;
            cur_ff.ready     <= 1'b1;
            cur_ff.phase     <= idw_pkg::PH_IDLE;
            cur_ff.code      <= idw_pkg::CODE_RESET;
            cur_ff.mode      <= idw_pkg::MODE_RESET;
        end else if (ce) begin
            cur_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Open-drain data line: only ever pulled low.
    assign sdaOut = 1'b0;
    assign sdaOe  = cur_ff.ackDrive;

    // The stored code is never touched by a mode change alone.
    assign codeOut          = cur_ff.code;
    assign powerModeHighBit = cur_ff.mode[1];
    assign powerModeLowBit  = cur_ff.mode[0];
    // Power and termination pins come straight from registers.
    assign poweredDown      = cur_ff.pdOut;
    assign ampConnected     = cur_ff.ampOut;
    assign termLow          = cur_ff.termLo;
    assign termHigh         = cur_ff.termHi;
    assign termOpen         = cur_ff.termOp;
    assign outputReady      = cur_ff.ready;
    assign updatePulse      = cur_ff.update;
    assign addressed        = (cur_ff.phase == idw_pkg::PH_CTRL) ||
                              (cur_ff.phase == idw_pkg::PH_DATA);

endmodule

`default_nettype wire

// ### design/idw_pkg.sv
// Shared constants and types of the two-wire converter write receiver.
// Assumes a 40 MHz system clock; the wake-up counts below are derived from it.

package idw_pkg;

    // ------------------------------------------------------------------
    // System clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;

    // ------------------------------------------------------------------
    // Address byte layout
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_FIXED     = 6'h26;
    localparam logic [7:0] ADDR_BROADCAST = 8'h90;
    localparam logic       DIR_WRITE      = 1'b0;

    // ------------------------------------------------------------------
    // Control byte layout
    // ------------------------------------------------------------------
    localparam int MODE_MSB  = 5;
    localparam int MODE_LSB  = 4;
    localparam int HIGH_MSB  = 3;
    localparam int HIGH_LSB  = 0;
    localparam int CODE_W    = 12;

    // ------------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_PD_1K    = 2'h1;
    localparam logic [1:0] MODE_PD_100K  = 2'h2;
    localparam logic [1:0] MODE_PD_OPEN  = 2'h3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [1:0]  MODE_RESET = 2'h0;

    // ------------------------------------------------------------------
    // Bit framing
    // ------------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_SLOT      = 4'h9;
    localparam logic [1:0] STRAP_SETTLE  = 2'h3;

    // ------------------------------------------------------------------
    // Wake-up time from power-down
    // ------------------------------------------------------------------
    localparam int WAKE_5V_NS = 2500;
    localparam int WAKE_3V_NS = 5000;
    localparam logic [7:0] WAKE_5V_CYC =
        8'((WAKE_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WAKE_3V_CYC =
        8'((WAKE_3V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ADDR,
        PH_CTRL,
        PH_DATA
    } idw_phase_t;

endpackage

// ### design/idw_link_sampler.sv
// Link-clock side of the receiver: samples the data line on each rising
// edge of the bus clock and flags every sample with a toggle.
// Assumes the bus clock may stop between frames; the reset is taken only on its rising edge.

`timescale 1ns/1ps
`default_nettype none

module idw_link_sampler (
    input  wire logic sclLink,
    input  wire logic rst_n,
    input  wire logic sdaIn,
    output logic      bitToggle,
    output logic      bitValue
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic tog;
        logic bitv;
    } idw_link_state_t;

    idw_link_state_t cur_ff;
    idw_link_state_t nxt_state;

    // ------------------------------------------------------------------
    // Sampling
    // ------------------------------------------------------------------
    // The line is stable for the whole high phase, so the rising edge
    // is a safe sampling point; the toggle and the bit change together.
    always_comb begin
        nxt_state      = cur_ff;
        nxt_state.bitv = sdaIn;
        nxt_state.tog  = ~cur_ff.tog;
    end

    always_ff @(posedge sclLink) begin
        if (!rst_n) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_state;
        end
    end

    assign bitToggle = cur_ff.tog;
    assign bitValue  = cur_ff.bitv;

endmodule

`default_nettype wire

// ### test/idw_dac_receiver_props.sv
// Concurrent checks on the ports of the converter write receiver.
// Assumes one clk_sys domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module idw_dac_receiver_props (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        scl,
    input wire logic        lowSupply,
    input wire logic        sdaOe,
    input wire logic [11:0] codeOut,
    input wire logic        powerModeHighBit,
    input wire logic        powerModeLowBit,
    input wire logic        poweredDown,
    input wire logic        ampConnected,
    input wire logic        termLow,
    input wire logic        termHigh,
    input wire logic        termOpen,
    input wire logic        outputReady,
    input wire logic        updatePulse,
    input wire logic        addressed
);
    // ----------------------------------------------------------------
    // Wake length counter
    // ----------------------------------------------------------------
    logic [1:0] mode;
    logic [8:0] lowCnt_ff;
    logic [8:0] wakeLen;
    assign mode = {powerModeHighBit, powerModeLowBit};
    assign wakeLen = lowSupply ? 9'(idw_pkg::WAKE_3V_CYC)
                               : 9'(idw_pkg::WAKE_5V_CYC);
    always_ff @(posedge clk_sys) begin
        if (!rst_n || outputReady || poweredDown) lowCnt_ff <= 9'h000;
        else if (ce && lowCnt_ff != 9'h1ff) lowCnt_ff <= lowCnt_ff + 9'h001;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_term_select: assert property (
        {termOpen, termHigh, termLow} ==
        {mode == 2'h3, mode == 2'h2, mode == 2'h1})
        else $error("termination does not follow mode");
    a_amp_cut: assert property (
        ampConnected == (mode == 2'h0) && poweredDown == (mode != 2'h0))
        else $error("amplifier state does not follow mode");
    a_code_hold: assert property ($changed(codeOut) |-> updatePulse)
        else $error("code changed without update");
    a_mode_hold: assert property ($changed(mode) |-> updatePulse)
        else $error("mode changed without update");
    a_update_one: assert property (updatePulse |=> !updatePulse)
        else $error("update pulse longer than one cycle");
    a_update_session: assert property (updatePulse |-> addressed)
        else $error("update outside a session");
    a_ack_stable: assert property (
        scl && $past(scl) |-> $stable(sdaOe))
        else $error("acknowledge moved while clock high");
    a_ready_mode: assert property (outputReady |-> ampConnected)
        else $error("ready while powered down");
    a_wake_len: assert property (
        $rose(outputReady) |->
        lowCnt_ff >= wakeLen && lowCnt_ff <= wakeLen + 9'h002)
        else $error("wake time wrong");
    a_reset_code: assert property (
        $rose(rst_n) |-> codeOut == 12'h000 && mode == 2'h0)
        else $error("code not cleared by reset");
    c_update: cover property (updatePulse);
    c_wake: cover property ($rose(outputReady));
    c_ack: cover property ($rose(sdaOe));
    c_open: cover property (termOpen);
endmodule
bind idw_dac_receiver idw_dac_receiver_props u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .lowSupply(lowSupply),
    .sdaOe(sdaOe), .codeOut(codeOut), .powerModeHighBit(powerModeHighBit),
    .powerModeLowBit(powerModeLowBit), .poweredDown(poweredDown),
    .ampConnected(ampConnected), .termLow(termLow), .termHigh(termHigh),
    .termOpen(termOpen), .outputReady(outputReady),
    .updatePulse(updatePulse), .addressed(addressed), .ce(ce));
`default_nettype wire

// ### test/idw_bus_master.sv
// Two-wire bus master model: start, stop, byte write with ack sample.
// Assumes a pulled-up data wire resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module idw_bus_master (
    input  wire logic linkClk,
    input  wire logic sda,
    output logic      scl,
    output logic      sdaDrv
);
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge linkClk);
    endtask
    // One clock pulse on an idle bus, so the link side takes its reset.
    task automatic clockPulse();
        tick(1);
        scl <= 1'b0;
        tick(1);
        scl <= 1'b1;
    endtask
    task automatic startCond();
        tick(1);
        sdaDrv <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(5);
        sdaDrv <= 1'b0;
        tick(5);
        scl <= 1'b0;
        tick(3);
    endtask
    // Data changes only in the low phase and stands while the clock is high.
    task automatic sendBit(input logic b);
        sdaDrv <= b;
        tick(2);
        scl <= 1'b1;
        tick(5);
        scl <= 1'b0;
        tick(3);
    endtask
    task automatic writeByte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) sendBit(v[i]);
        sdaDrv <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(3);
        ack = ~sda;
        tick(2);
        scl <= 1'b0;
        tick(3);
    endtask
    task automatic stopCond();
        sdaDrv <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(5);
        sdaDrv <= 1'b1;
        tick(5);
    endtask
endmodule
`default_nettype wire

// ### test/test_idw_dac_receiver.sv
// Self-checking bench of the converter write receiver.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_idw_dac_receiver;
    logic        clk_sys = 1'b0;
    logic        linkClk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        selPin = 1'b1;
    logic        lowSupply = 1'b0;
    logic        scl, sdaDrv, sdaOut, sdaOe, ack, pmHi, pmLo, pd, amp;
    logic        tLow, tHigh, tOpen, outputReady, updatePulse, addressed;
    logic [11:0] codeOut;
    logic [6:0]  outSt;
    int          num_errors = 0, checked = 0, nUpd = 0;
    logic [7:0]  badAddr [4] = '{8'h98, 8'h9b, 8'h00, 8'hf0};
    wire logic   sda = sdaDrv & ~(sdaOe & ~sdaOut);
    assign outSt = {pmHi, pmLo, pd, tOpen, tHigh, tLow, amp};
    always #12.5 clk_sys = ~clk_sys;
    initial #7 forever #62.5 linkClk = ~linkClk;
    always @(posedge clk_sys) if (updatePulse === 1'b1) nUpd <= nUpd + 1;
    idw_dac_receiver uut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .scl(scl), .sdaIn(sda), .addressSelectPin(selPin),
        .lowSupply(lowSupply), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .codeOut(codeOut), .powerModeHighBit(pmHi), .powerModeLowBit(pmLo),
        .poweredDown(pd), .ampConnected(amp), .termLow(tLow),
        .termHigh(tHigh), .termOpen(tOpen), .outputReady(outputReady),
        .updatePulse(updatePulse), .addressed(addressed));
    idw_bus_master mst (.linkClk(linkClk), .sda(sda), .scl(scl),
        .sdaDrv(sdaDrv));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic pair(input logic [7:0] c, d, input logic exp);
        mst.writeByte(c, ack);
        check(12'(ack), 12'(exp));
        mst.writeByte(d, ack);
        check(12'(ack), 12'(exp));
    endtask
    task automatic session(input logic [7:0] a, c, d, input logic exp);
        mst.startCond();
        mst.writeByte(a, ack);
        check(12'(ack), 12'(exp));
        pair(c, d, exp);
    endtask
    // Ready stays low through the wake time, then comes back.
    task automatic wakeCheck(input int n);
        repeat (n - 40) @(negedge clk_sys);
        check(12'(outputReady), 12'h000);
        repeat (60) @(negedge clk_sys);
        check(12'(outputReady), 12'h001);
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        // The link side resets on a bus clock edge, so pulse it once.
        fork
            mst.clockPulse();
            repeat (12) @(posedge clk_sys);
        join
        rst_n <= 1'b1;
        repeat (20) @(posedge clk_sys);
        selPin <= 1'b0;
        @(negedge clk_sys);
        check(codeOut, 12'h000);
        check(12'(outSt), 12'h001);
        $display("test reset done");
        session(8'h9a, 8'hc5, 8'ha3, 1'b1);
        check(codeOut, 12'h5a3);
        check(12'(outSt), 12'h001);
        pair(8'h1f, 8'h12, 1'b1);
        check(codeOut, 12'hf12);
        check(12'(outSt), 12'h032);
        check(12'(addressed), 12'h001);
        $display("test write pairs done");
        for (int m = 0; m < 4; m++) begin
            session(8'h90, 8'(m * 16 + 7), 8'h55, 1'b1);
            check(codeOut, 12'h755);
            check(12'(outSt), 12'({2'(m), m>0, 4'(1 << m)}));
        end
        $display("test modes done");
        session(8'h9a, 8'h07, 8'h55, 1'b1);
        wakeCheck(100);
        pair(8'h17, 8'h55, 1'b1);
        @(posedge clk_sys);
        lowSupply <= 1'b1;
        pair(8'h07, 8'h55, 1'b1);
        @(posedge clk_sys);
        ce <= 1'b0;
        repeat (150) @(posedge clk_sys);
        ce <= 1'b1;
        wakeCheck(200);
        $display("test wake done");
        mst.stopCond();
        check(12'(addressed), 12'h000);
        foreach (badAddr[i]) begin
            session(badAddr[i], 8'h3f, 8'hff, 1'b0);
            check(codeOut, 12'h755);
            check(12'(addressed), 12'h000);
        end
        mst.stopCond();
        mst.writeByte(8'h9a, ack);
        check(12'(ack), 12'h000);
        check(12'(nUpd), 12'h009);
        $display("test refusals done");
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
